/* File: shared/upf_map.svh */
// Offsets, field positions, reset values and timing counts of the pin block
`ifndef UPF_MAP_SVH
`define UPF_MAP_SVH

// Channel select bit in the byte address; channel B sits at 0x20
`define UPF_CHAN_SEL_BIT      5
// Upper address bits that must be zero for a mapped access
`define UPF_ADDR_HI_BIT       31
`define UPF_ADDR_HI_LO        6

// Word index of each register inside one channel (byte = index * 4)
`define UPF_IDX_MODEM_CTRL    3'h0
`define UPF_IDX_ALT_FUNC      3'h1
`define UPF_IDX_FEATURE       3'h2
`define UPF_IDX_ENH_FEATURE   3'h3
`define UPF_IDX_EXT_STATUS    3'h4
`define UPF_IDX_INT_ENABLE    3'h5
`define UPF_IDX_PIN_STATUS    3'h6

// Field positions
`define UPF_MCR_TERM_READY    0
`define UPF_MCR_REQ_SEND      1
`define UPF_MCR_GEN_OUT_TWO   3
`define UPF_MCR_INFRARED      6
`define UPF_AFR_SEL_HI        2
`define UPF_AFR_SEL_LO        1
`define UPF_FEATURE_CONTROL_RX_INVERT    2
`define UPF_FEATURE_CONTROL_HALF_DUPLEX  3
`define UPF_EFR_AUTO_RTS      6
`define UPF_EFR_AUTO_CTS      7
`define UPF_EXTENDED_MODEM_STATUS_HALF_DUPLEX  3

// Reset values
`define UPF_REG_RESET         8'h00
`define UPF_SYNC_RESET        5'h1F

// Reset pulse: 40 ns least, in 8 ns cycles rounded up
`define UPF_RESET_MIN_NS      40
`define UPF_CLK_PERIOD_NS     8
`define UPF_RESET_MIN_CYC \
  ((`UPF_RESET_MIN_NS + `UPF_CLK_PERIOD_NS - 1) / `UPF_CLK_PERIOD_NS)

`endif

/* File: shared/upf_pkg.sv */
// Types shared by the pin-function block
package upf_pkg;

  typedef logic [7:0] upf_byte_t;

  // Multi-function pin source select
  typedef enum logic [1:0]
  {
    UPF_MF_GEN_OUT   = 2'h0,
    UPF_MF_RATE_CLK  = 2'h1,
    UPF_MF_RX_READY  = 2'h2,
    UPF_MF_RESERVED  = 2'h3
  } upf_mf_sel_t;

  // Bus slave states, one-hot
  typedef enum logic [3:0]
  {
    UPF_ST_IDLE    = 4'h1,
    UPF_ST_WRITE   = 4'h2,
    UPF_ST_RD_WAIT = 4'h4,
    UPF_ST_RD_DONE = 4'h8
  } upf_state_t;

endpackage

/* File: shared/upf_chan_if.sv */
// Configuration and status carrier between register file and one channel
`timescale 1ns/1ps
interface upf_chan_if;
  import upf_pkg::*;

  upf_byte_t   modem_ctrl;
  upf_byte_t   alt_func;
  upf_byte_t   feature;
  upf_byte_t   enh_feature;
  upf_byte_t   ext_status;
  logic [6:0]  pin_status;

  modport regs
  (
    output modem_ctrl,
    output alt_func,
    output feature,
    output enh_feature,
    output ext_status,
    input  pin_status
  );

  modport pins
  (
    input  modem_ctrl,
    input  alt_func,
    input  feature,
    input  enh_feature,
    input  ext_status,
    output pin_status
  );
endinterface

/* File: rtl/upf_chan_pins.sv */
// Pin-function logic of one serial channel
`timescale 1ns/1ps
`include "upf_map.svh"
module upf_chan_pins
  import upf_pkg::*;
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  upf_chan_if.pins   cfg,
  input  wire logic  serial_in,
  input  wire logic  clear_send_n,
  input  wire logic  set_ready_in_n,
  input  wire logic  carrier_in_n,
  input  wire logic  ring_in_n,
  output logic       serial_out,
  output logic       request_send_n,
  output logic       terminal_ready_n,
  output logic       multifunction_out_n,
  input  wire logic  core_tx_bit,
  input  wire logic  core_ir_bit,
  input  wire logic  core_tx_active,
  input  wire logic  core_rate_clk,
  input  wire logic  core_rx_ready,
  input  wire logic  core_rts_hold,
  output logic       core_rx_bit,
  output logic       core_tx_permit
);

  logic [4:0]   sync1;
  logic [4:0]   sync2;
  logic [4:0]   sync3;
  logic [4:0]   pin_level;
  logic         infrared;
  logic         half_duplex;
  upf_mf_sel_t  mf_sel;

  assign infrared    = cfg.modem_ctrl[`UPF_MCR_INFRARED];
  assign half_duplex = cfg.feature[`UPF_FEATURE_CONTROL_HALF_DUPLEX]
                     & cfg.ext_status[`UPF_EXTENDED_MODEM_STATUS_HALF_DUPLEX];
  assign mf_sel      = upf_mf_sel_t'(
    cfg.alt_func[`UPF_AFR_SEL_HI:`UPF_AFR_SEL_LO]);

  // Three-stage input synchroniser; idle level high on every pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= `UPF_SYNC_RESET;
      sync2 <= `UPF_SYNC_RESET;
      sync3 <= `UPF_SYNC_RESET;
    end
    else
    begin
      sync1 <= {serial_in, clear_send_n, set_ready_in_n,
                carrier_in_n, ring_in_n};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_level <= `UPF_SYNC_RESET;
    else
      pin_level <= (sync3 & ~(sync2 ^ sync3)) | (pin_level & (sync2 ^ sync3));
  end

  // status only
  // Set-ready, carrier and ring reach status and nothing else
  assign cfg.pin_status = {request_send_n, core_tx_permit, core_rx_bit,
                           pin_level[3:0]};

  // Transmit pin and receive path
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_out  <= 1'b1;
      core_rx_bit <= 1'b1;
    end
    else
    begin
      if (infrared)
        serial_out <= core_tx_active ? core_ir_bit : 1'b0;
      else
        serial_out <= core_tx_active ? core_tx_bit : 1'b1;
      if (infrared && cfg.feature[`UPF_FEATURE_CONTROL_RX_INVERT])
        core_rx_bit <= ~pin_level[4];
      else
        core_rx_bit <= pin_level[4];
    end
  end

  // Modem-control outputs and clear-to-send gate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      request_send_n   <= 1'b1;
      terminal_ready_n <= 1'b1;
      core_tx_permit   <= 1'b1;
    end
    else
    begin
      if (half_duplex)
        request_send_n <= ~core_tx_active;
      else if (cfg.enh_feature[`UPF_EFR_AUTO_RTS])
        request_send_n <= ~(cfg.modem_ctrl[`UPF_MCR_REQ_SEND]
                            & ~core_rts_hold);
      else
        request_send_n <= ~cfg.modem_ctrl[`UPF_MCR_REQ_SEND];
      terminal_ready_n <= ~cfg.modem_ctrl[`UPF_MCR_TERM_READY];
      core_tx_permit <= cfg.enh_feature[`UPF_EFR_AUTO_CTS] ?
                        ~pin_level[3] : 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      multifunction_out_n <= 1'b1;
    else
      case (mf_sel)
        UPF_MF_GEN_OUT:
          multifunction_out_n <= ~cfg.modem_ctrl[`UPF_MCR_GEN_OUT_TWO];
        UPF_MF_RATE_CLK:
          multifunction_out_n <= core_rate_clk;
        UPF_MF_RX_READY:
          multifunction_out_n <= ~core_rx_ready;
        default:
          multifunction_out_n <= 1'b1; // Reserved code parks inactive
      endcase
  end

endmodule

/* File: rtl/upf_pin_func.sv */
// Dual-channel serial pin-function block with AHB-Lite register access
//
// Function
// - Set-ready, carrier and ring inputs are status only, steer nothing.
// - Multi-function pin picks one of three sources by select bits 2:1.
// - General-output source drives pin low while modem-control bit 3 is set.
// - Modem-control bit 3 clears on every reset.
// - Rate-clock source drives the sixteen-times baud clock onto the pin.
// - Receive-ready source gives an active-low receive data ready indication.
// - Standard mode: transmit pin high in reset and whenever idle.
// - Infrared mode: transmit pin rests low while idle.
// - Receive idles high; infrared input may be inverted by feature bit 2.
// - Request-to-send may act as half-duplex direction control.
// - Clear-to-send is plain input or, when enabled, gates transmission.
// - Terminal-ready is a plain software-driven active-low output.
// - Reset clears registers and outputs; transmit high, receive ignored.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "upf_map.svh"
module upf_pin_func
  import upf_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic         chan_a_serial_in,
  output logic              chan_a_serial_out,
  output logic              chan_a_request_send_n,
  input  wire logic         chan_a_clear_send_n,
  output logic              chan_a_terminal_ready_n,
  input  wire logic         chan_a_set_ready_in_n,
  input  wire logic         chan_a_carrier_in_n,
  input  wire logic         chan_a_ring_in_n,
  output logic              chan_a_multifunction_out_n,
  input  wire logic         chan_b_serial_in,
  output logic              chan_b_serial_out,
  output logic              chan_b_request_send_n,
  input  wire logic         chan_b_clear_send_n,
  output logic              chan_b_terminal_ready_n,
  input  wire logic         chan_b_set_ready_in_n,
  input  wire logic         chan_b_carrier_in_n,
  input  wire logic         chan_b_ring_in_n,
  output logic              chan_b_multifunction_out_n,
  input  wire logic [1:0]   core_tx_bit,
  input  wire logic [1:0]   core_ir_bit,
  input  wire logic [1:0]   core_tx_active,
  input  wire logic [1:0]   core_rate_clk,
  input  wire logic [1:0]   core_rx_ready,
  input  wire logic [1:0]   core_rts_hold,
  output logic [1:0]        core_rx_bit,
  output logic [1:0]        core_tx_permit
);

  localparam int NUM_CHAN = 2;

  upf_state_t  state;
  upf_state_t  next_state;
  logic        accept;
  logic        addr_mapped;
  logic        sel_chan;
  logic [2:0]  sel_idx;
  logic        sel_valid;
  logic [7:0]  read_byte;
  logic [7:0]  write_en;

  // Per-channel register storage
  upf_byte_t   modem_ctrl  [NUM_CHAN];
  upf_byte_t   alt_func    [NUM_CHAN];
  upf_byte_t   feature     [NUM_CHAN];
  upf_byte_t   enh_feature [NUM_CHAN];
  upf_byte_t   ext_status  [NUM_CHAN];
  upf_byte_t   int_enable  [NUM_CHAN];
  logic [6:0]  pin_status  [NUM_CHAN];

  upf_chan_if  chan_a_if ();
  upf_chan_if  chan_b_if ();

  // Address phase is taken only on an active transfer with the bus ready
  assign accept = hsel & hready & htrans[1];

  // Upper bits must be clear; indices past the status word are unmapped
  assign addr_mapped =
    (haddr[`UPF_ADDR_HI_BIT:`UPF_ADDR_HI_LO] == 26'h0)
    && (haddr[4:2] <= `UPF_IDX_PIN_STATUS);

  // Always OKAY; reads stall one cycle so a read right after a write
  // sees the freshly written value without any forwarding path
  assign hresp     = 1'b0;
  assign hreadyout = (state != UPF_ST_RD_WAIT);

  // Slave state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= UPF_ST_IDLE;
    else
      state <= next_state;
  end

  // Next state: new address phases only while the slave is ready
  always_comb
  begin
    next_state = UPF_ST_IDLE;
    case (state)
      UPF_ST_IDLE,
      UPF_ST_WRITE,
      UPF_ST_RD_DONE:
      begin
        if (accept)
          next_state = hwrite ? UPF_ST_WRITE : UPF_ST_RD_WAIT;
        else
          next_state = UPF_ST_IDLE;
      end
      UPF_ST_RD_WAIT:
        next_state = UPF_ST_RD_DONE;
      default:
        next_state = UPF_ST_IDLE;
    endcase
  end

  // Channel of the captured address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_chan <= 1'b0;
    else if (accept)
      sel_chan <= haddr[`UPF_CHAN_SEL_BIT];
  end

  // Word index of the captured address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_idx <= 3'h0;
    else if (accept)
      sel_idx <= haddr[4:2];
  end

  // Mapped flag; an unmapped access reads zero and writes nothing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_valid <= 1'b0;
    else if (accept)
      sel_valid <= addr_mapped;
  end

  // One write enable per word; the status word has no register behind it
  always_comb
  begin
    write_en = 8'h00;
    if ((state == UPF_ST_WRITE) && sel_valid)
      write_en[sel_idx] = 1'b1;
  end

  // Modem control: bit 3 must start clear so the general output is off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NUM_CHAN; ch++)
        modem_ctrl[ch] <= `UPF_REG_RESET;
    end
    else if (write_en[`UPF_IDX_MODEM_CTRL])
      modem_ctrl[sel_chan] <= hwdata[7:0];
  end

  // Alternate function: select code 0 keeps the general output at reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NUM_CHAN; ch++)
        alt_func[ch] <= `UPF_REG_RESET;
    end
    else if (write_en[`UPF_IDX_ALT_FUNC])
      alt_func[sel_chan] <= hwdata[7:0];
  end

  // Feature control: inversion and half-duplex enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NUM_CHAN; ch++)
        feature[ch] <= `UPF_REG_RESET;
    end
    else if (write_en[`UPF_IDX_FEATURE])
      feature[sel_chan] <= hwdata[7:0];
  end

  // Enhanced feature: automatic flow control enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NUM_CHAN; ch++)
        enh_feature[ch] <= `UPF_REG_RESET;
    end
    else if (write_en[`UPF_IDX_ENH_FEATURE])
      enh_feature[sel_chan] <= hwdata[7:0];
  end

  // Extended status: half-duplex select, other bits only stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NUM_CHAN; ch++)
        ext_status[ch] <= `UPF_REG_RESET;
    end
    else if (write_en[`UPF_IDX_EXT_STATUS])
      ext_status[sel_chan] <= hwdata[7:0];
  end

  // Interrupt enable: stored for software, no interrupt logic here
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NUM_CHAN; ch++)
        int_enable[ch] <= `UPF_REG_RESET;
    end
    else if (write_en[`UPF_IDX_INT_ENABLE])
      int_enable[sel_chan] <= hwdata[7:0];
  end

  // Read selection from the captured address
  always_comb
  begin
    read_byte = 8'h00;
    if (sel_valid)
    begin
      case (sel_idx)
        `UPF_IDX_MODEM_CTRL:  read_byte = modem_ctrl[sel_chan];
        `UPF_IDX_ALT_FUNC:    read_byte = alt_func[sel_chan];
        `UPF_IDX_FEATURE:     read_byte = feature[sel_chan];
        `UPF_IDX_ENH_FEATURE: read_byte = enh_feature[sel_chan];
        `UPF_IDX_EXT_STATUS:  read_byte = ext_status[sel_chan];
        `UPF_IDX_INT_ENABLE:  read_byte = int_enable[sel_chan];
        `UPF_IDX_PIN_STATUS:  read_byte = {1'b0, pin_status[sel_chan]};
        default:              read_byte = 8'h00;
      endcase
    end
  end

  // Read data is loaded during the wait cycle and held until the next read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (state == UPF_ST_RD_WAIT)
      hrdata <= {24'h00_0000, read_byte};
  end

  // Configuration out to channel A
  assign chan_a_if.modem_ctrl  = modem_ctrl[0];
  assign chan_a_if.alt_func    = alt_func[0];
  assign chan_a_if.feature     = feature[0];
  assign chan_a_if.enh_feature = enh_feature[0];
  assign chan_a_if.ext_status  = ext_status[0];
  assign pin_status[0]         = chan_a_if.pin_status;

  // Configuration out to channel B
  assign chan_b_if.modem_ctrl  = modem_ctrl[1];
  assign chan_b_if.alt_func    = alt_func[1];
  assign chan_b_if.feature     = feature[1];
  assign chan_b_if.enh_feature = enh_feature[1];
  assign chan_b_if.ext_status  = ext_status[1];
  assign pin_status[1]         = chan_b_if.pin_status;

  upf_chan_pins u_chan_a
  (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .cfg                 (chan_a_if.pins),
    .serial_in           (chan_a_serial_in),
    .clear_send_n        (chan_a_clear_send_n),
    .set_ready_in_n      (chan_a_set_ready_in_n),
    .carrier_in_n        (chan_a_carrier_in_n),
    .ring_in_n           (chan_a_ring_in_n),
    .serial_out          (chan_a_serial_out),
    .request_send_n      (chan_a_request_send_n),
    .terminal_ready_n    (chan_a_terminal_ready_n),
    .multifunction_out_n (chan_a_multifunction_out_n),
    .core_tx_bit         (core_tx_bit[0]),
    .core_ir_bit         (core_ir_bit[0]),
    .core_tx_active      (core_tx_active[0]),
    .core_rate_clk       (core_rate_clk[0]),
    .core_rx_ready       (core_rx_ready[0]),
    .core_rts_hold       (core_rts_hold[0]),
    .core_rx_bit         (core_rx_bit[0]),
    .core_tx_permit      (core_tx_permit[0])
  );

  upf_chan_pins u_chan_b
  (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .cfg                 (chan_b_if.pins),
    .serial_in           (chan_b_serial_in),
    .clear_send_n        (chan_b_clear_send_n),
    .set_ready_in_n      (chan_b_set_ready_in_n),
    .carrier_in_n        (chan_b_carrier_in_n),
    .ring_in_n           (chan_b_ring_in_n),
    .serial_out          (chan_b_serial_out),
    .request_send_n      (chan_b_request_send_n),
    .terminal_ready_n    (chan_b_terminal_ready_n),
    .multifunction_out_n (chan_b_multifunction_out_n),
    .core_tx_bit         (core_tx_bit[1]),
    .core_ir_bit         (core_ir_bit[1]),
    .core_tx_active      (core_tx_active[1]),
    .core_rate_clk       (core_rate_clk[1]),
    .core_rx_ready       (core_rx_ready[1]),
    .core_rts_hold       (core_rts_hold[1]),
    .core_rx_bit         (core_rx_bit[1]),
    .core_tx_permit      (core_tx_permit[1])
  );

endmodule

/* File: bench/upf_line_partner.sv */
// Line-side model: transceiver pins of both channels
`timescale 1ns/1ps
module upf_line_partner
(
  input  wire logic [1:0] infrared,
  input  wire logic [1:0] rx_on,
  input  wire logic [1:0] rx_bit,
  input  wire logic [7:0] modem_n,
  output logic      [1:0] serial_in,
  output logic      [7:0] modem_pins_n
);
  // idle line level
  // Released line: standard idles high, infrared pulses idle low
  assign serial_in = (rx_on & rx_bit) | (~rx_on & ~infrared);
  // Modem lines pass straight through from the far side, with no pull-up
  assign modem_pins_n = modem_n;
endmodule

/* File: bench/upf_pin_func_props.sv */
// Port assertions for the pin-function block
`timescale 1ns/1ps
module upf_pin_func_props
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        chan_a_serial_out,
  input wire logic        chan_a_terminal_ready_n,
  input wire logic        chan_a_multifunction_out_n,
  input wire logic        chan_a_clear_send_n,
  input wire logic [1:0]  core_tx_bit,
  input wire logic [1:0]  core_tx_active,
  input wire logic [1:0]  core_rate_clk,
  input wire logic [1:0]  core_rx_ready,
  input wire logic [1:0]  core_tx_permit
);
  logic       wr_pend;
  logic [2:0] wr_idx;
  logic [7:0] mcr_a;
  logic [7:0] afr_a;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Address phase of a channel A write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_pend <= 1'b0;
    else if (hready)
      wr_pend <= hsel && htrans[1] && hwrite && haddr[31:5] == 27'h0;

  // Index kept apart; only meaningful while wr_pend
  always_ff @(posedge hclk)
    if (hready)
      wr_idx <= haddr[4:2];

  // Shadow of two channel A registers; pins lag them one cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      mcr_a <= 8'h00;
      afr_a <= 8'h00;
    end
    else if (wr_pend && hready)
    begin
      if (wr_idx == 3'h0)
        mcr_a <= hwdata[7:0];
      if (wr_idx == 3'h1)
        afr_a <= hwdata[7:0];
    end

  chk_reset_pins_idle: assert property (
    $rose(hresetn) |-> chan_a_serial_out && chan_a_terminal_ready_n
      && chan_a_multifunction_out_n) else $error("pins not idle");
  chk_ready_tracks_reg: assert property (
    chan_a_terminal_ready_n == !$past(mcr_a[0])) else $error("ready pin");
  chk_mf_general_out: assert property (
    $past(afr_a[2:1]) == 2'h0 |->
      chan_a_multifunction_out_n == !$past(mcr_a[3])) else $error("op2");
  chk_mf_rate_clock: assert property (
    $past(afr_a[2:1]) == 2'h1 |->
      chan_a_multifunction_out_n == $past(core_rate_clk[0]))
    else $error("rate clock");
  chk_mf_rx_ready: assert property (
    $past(afr_a[2:1]) == 2'h2 |->
      chan_a_multifunction_out_n == !$past(core_rx_ready[0]))
    else $error("rx ready");
  chk_tx_idle_level: assert property (
    !$past(core_tx_active[0]) |-> chan_a_serial_out == !$past(mcr_a[6]))
    else $error("tx idle");
  chk_tx_std_data: assert property (
    $past(hresetn && core_tx_active[0] && !mcr_a[6]) |->
      chan_a_serial_out == $past(core_tx_bit[0])) else $error("tx data");
  chk_permit_cts_low: assert property (
    !chan_a_clear_send_n [*6] |-> core_tx_permit[0]) else $error("permit");
  chk_read_one_wait: assert property (
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait");
endmodule

/* File: bench/upf_pin_func_bench.sv */
// Self-checking bench of the dual-channel pin-function block
`timescale 1ns/1ps
module upf_pin_func_bench;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  wire         hreadyout;
  wire         hresp;
  logic [1:0]  tx_bit, ir_bit, tx_act, rate_clk, rx_rdy, rts_hold;
  logic [1:0]  rx_bit, tx_permit, p_ir, p_on, p_bit, sin;
  logic [7:0]  modem_n, ml_n;
  wire  [3:0]  pa, pb;
  wire  [11:0] pins_v = {rx_bit, tx_permit, pa, pb};
  logic [4:0]  mf_tab [6] = '{5'h0D, 5'h08, 5'h12, 5'h11, 5'h1B, 5'h00};
  int          num_errors, n_checks;

  // Pin groups: serial out, request, ready, multifunction
  upf_pin_func i_upf_pin_func
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(hresp),
    .chan_a_serial_in(sin[0]), .chan_a_serial_out(pa[3]),
    .chan_a_request_send_n(pa[2]), .chan_a_clear_send_n(ml_n[3]),
    .chan_a_terminal_ready_n(pa[1]), .chan_a_set_ready_in_n(ml_n[2]),
    .chan_a_carrier_in_n(ml_n[1]), .chan_a_ring_in_n(ml_n[0]),
    .chan_a_multifunction_out_n(pa[0]),
    .chan_b_serial_in(sin[1]), .chan_b_serial_out(pb[3]),
    .chan_b_request_send_n(pb[2]), .chan_b_clear_send_n(ml_n[7]),
    .chan_b_terminal_ready_n(pb[1]), .chan_b_set_ready_in_n(ml_n[6]),
    .chan_b_carrier_in_n(ml_n[5]), .chan_b_ring_in_n(ml_n[4]),
    .chan_b_multifunction_out_n(pb[0]),
    .core_tx_bit(tx_bit), .core_ir_bit(ir_bit), .core_tx_active(tx_act),
    .core_rate_clk(rate_clk), .core_rx_ready(rx_rdy),
    .core_rts_hold(rts_hold), .core_rx_bit(rx_bit),
    .core_tx_permit(tx_permit)
  );

  upf_line_partner i_upf_line_partner
  (
    .infrared(p_ir), .rx_on(p_on), .rx_bit(p_bit), .modem_n(modem_n),
    .serial_in(sin), .modem_pins_n(ml_n)
  );

  // Free-running bus clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for the slave; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(q, {24'h0, e});
    // Slave answers OKAY on every transfer
    check({31'h0, hresp}, 32'h0);
  endtask

  // Let synchronisers and output flops settle before looking
  task automatic pchk(input logic [11:0] e);
    repeat (8) @(posedge hclk);
    check({20'h0, pins_v}, {20'h0, e});
  endtask

  // Main sequence
  initial
  begin
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    {tx_bit, ir_bit, tx_act, rate_clk, rx_rdy, rts_hold} = '0;
    {p_ir, p_on, p_bit} = '0;
    modem_n = 8'hFF;
    hresetn = 1'b0;
    num_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    pchk(12'hFFF);
    for (int i = 0; i < 7; i++)
    begin
      rd(32'(i * 4), i == 6 ? 8'h7F : 8'h00);
      rd(32'(i * 4 + 32), i == 6 ? 8'h7F : 8'h00);
    end
    wr(32'h1C, 8'hAA);
    rd(32'h1C, 8'h00);
    rd(32'h40, 8'h00);
    wr(32'h00, 8'h0B);
    pchk(12'hF8F);
    rd(32'h00, 8'h0B);
    rd(32'h18, 8'h3F);
    modem_n <= 8'hF8;
    pchk(12'hF8F);
    rd(32'h18, 8'h38);
    wr(32'h0C, 8'h80);
    pchk(12'hE8F);
    modem_n <= 8'hF0;
    pchk(12'hF8F);
    wr(32'h0C, 8'hC0);
    rts_hold <= 2'h1;
    pchk(12'hFCF);
    rts_hold <= 2'h0;
    wr(32'h08, 8'h08);
    wr(32'h10, 8'h08);
    tx_act <= 2'h1;
    pchk(12'hF0F);
    tx_act <= 2'h0;
    pchk(12'hFCF);
    for (int i = 0; i < 6; i++)
    begin
      rate_clk <= {1'b0, mf_tab[i][2]};
      rx_rdy <= {1'b0, mf_tab[i][1]};
      wr(32'h04, {5'h0, mf_tab[i][4:3], 1'b0});
      repeat (8) @(posedge hclk);
      check({31'h0, pa[0]}, {31'h0, mf_tab[i][0]});
    end
    p_ir <= 2'h1;
    wr(32'h00, 8'h4B);
    pchk(12'hB4F);
    wr(32'h08, 8'h0C);
    pchk(12'hF4F);
    ir_bit <= 2'h1;
    tx_act <= 2'h1;
    pchk(12'hF8F);
    tx_act <= 2'h0;
    p_on <= 2'h2;
    pchk(12'h74F);
    p_ir <= 2'h0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check({20'h0, pins_v}, 32'hFFF);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    pchk(12'h7FF);
    rd(32'h00, 8'h00);
    tally_and_finish();
  end
endmodule

bind upf_pin_func upf_pin_func_props i_upf_pin_func_props
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .chan_a_serial_out, .chan_a_terminal_ready_n,
  .chan_a_multifunction_out_n, .chan_a_clear_send_n, .core_tx_bit,
  .core_tx_active, .core_rate_clk, .core_rx_ready, .core_tx_permit
);
